//--- stab_chain_config_bank.sv
// Stabilization chain configuration register bank
`timescale 1ns/1ps
module stab_chain_config_bank #(
  parameter int CYC_50US = stab_chain_pkg::CYC_AVB_50US,
  parameter int CYC_1MS = stab_chain_pkg::CYC_AVB_1MS,
  parameter int CYC_25MS = stab_chain_pkg::CYC_AVB_25MS
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [7:0] host_addr,
  input wire logic [7:0] host_wdata,
  input wire logic host_wr,
  input wire logic host_rd,
  output logic [7:0] host_rdata,
  input wire logic [7:0] aux_addr,
  input wire logic [7:0] aux_wdata,
  input wire logic aux_wr,
  input wire logic aux_rd,
  output logic [7:0] aux_rdata,
  input wire logic [7:0] rate_deviation,
  input wire logic irq1_routed,
  input wire logic dyn_addr_assigned,
  input wire logic ibi_request,
  input wire logic bus_idle_pin,
  input wire logic data_enable_input,
  input wire logic gyro_sample_strobe,
  input wire logic stab_drdy,
  input wire logic irq2_other,
  output logic irq1_pulldown_on,
  output logic irq_pin_second,
  output logic ibi_start,
  output logic aux_three_wire,
  output logic gyro_stab_active,
  output logic accel_stab_active,
  output logic aux_gyro_visible,
  output logic aux_accel_visible,
  output logic first_lowpass_owned,
  output stab_chain_pkg::gyro_fs_t gyro_range,
  output logic [1:0] accel_selftest,
  output logic gyro_den_mark,
  output logic gyro_den_valid
);
  logic [7:0] bus_idle_cfg, next_bus_idle_cfg;
  logic [7:0] rate_dev_q, next_rate_dev_q;
  logic [7:0] stab_int, next_stab_int;
  logic [7:0] stab_ctrl, next_stab_ctrl;
  logic [7:0] next_host_rdata, next_aux_rdata;
  logic next_pd, next_irq2, next_three_wire;
  logic next_gyro_act, next_accel_act;
  logic [1:0] next_selftest;
  stab_chain_pkg::gyro_fs_t next_range;
  logic idle_meta, idle_sync, den_meta, den_sync;
  logic pd_dis, chain_en, accel_en;
  logic [1:0] st_field;
  stab_link_if lnk ();

  function automatic logic [7:0] read_reg(input logic [7:0] a);
    if (a == stab_chain_pkg::ADDR_BUS_IDLE) return bus_idle_cfg;
    else if (a == stab_chain_pkg::ADDR_RATE_DEV) return rate_dev_q;
    else if (a == stab_chain_pkg::ADDR_STAB_INT) return stab_int;
    else if (a == stab_chain_pkg::ADDR_STAB_CTRL) return stab_ctrl;
    else return stab_chain_pkg::READ_UNMAPPED;
  endfunction

  function automatic stab_chain_pkg::gyro_fs_t fs_sel(
    input logic low, input logic [1:0] r);
    if (low) return stab_chain_pkg::GYRO_FS_125;
    else if (r == stab_chain_pkg::RANGE_250)
      return stab_chain_pkg::GYRO_FS_250;
    else if (r == stab_chain_pkg::RANGE_500)
      return stab_chain_pkg::GYRO_FS_500;
    else if (r == stab_chain_pkg::RANGE_1000)
      return stab_chain_pkg::GYRO_FS_1000;
    else return stab_chain_pkg::GYRO_FS_2000;
  endfunction

  // Pin inputs cross into the system clock through two stages
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      idle_meta <= 1'b0;
      idle_sync <= 1'b0;
      den_meta <= 1'b0;
      den_sync <= 1'b0;
    end else begin
      idle_meta <= bus_idle_pin;
      idle_sync <= idle_meta;
      den_meta <= data_enable_input;
      den_sync <= den_meta;
    end
  end

  // Register writes
  always_comb begin
    next_bus_idle_cfg = bus_idle_cfg;
    next_stab_int = stab_int;
    next_stab_ctrl = stab_ctrl;
    next_rate_dev_q = rate_deviation;
    // Reserved bits are dropped, so a stray one cannot upset the device
    if (host_wr && host_addr == stab_chain_pkg::ADDR_BUS_IDLE)
      next_bus_idle_cfg = host_wdata & stab_chain_pkg::MASK_BUS_IDLE;
    // Only the aux port may change the stabilization registers
    if (aux_wr && aux_addr == stab_chain_pkg::ADDR_STAB_INT)
      next_stab_int = aux_wdata & stab_chain_pkg::MASK_STAB_INT;
    if (aux_wr && aux_addr == stab_chain_pkg::ADDR_STAB_CTRL)
      next_stab_ctrl = aux_wdata & stab_chain_pkg::MASK_STAB_CTRL;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      bus_idle_cfg <= stab_chain_pkg::RESET_REG;
      rate_dev_q <= stab_chain_pkg::RESET_REG;
      stab_int <= stab_chain_pkg::RESET_REG;
      stab_ctrl <= stab_chain_pkg::RESET_REG;
    end else begin
      bus_idle_cfg <= next_bus_idle_cfg;
      rate_dev_q <= next_rate_dev_q;
      stab_int <= next_stab_int;
      stab_ctrl <= next_stab_ctrl;
    end
  end

  // Read data, one cycle after the strobe; zero when idle
  always_comb begin
    next_host_rdata = host_rd ? read_reg(host_addr)
                              : stab_chain_pkg::READ_UNMAPPED;
    next_aux_rdata = aux_rd ? read_reg(aux_addr)
                            : stab_chain_pkg::READ_UNMAPPED;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      host_rdata <= stab_chain_pkg::READ_UNMAPPED;
      aux_rdata <= stab_chain_pkg::READ_UNMAPPED;
    end else begin
      host_rdata <= next_host_rdata;
      aux_rdata <= next_aux_rdata;
    end
  end

  // Decoded control outputs
  always_comb begin
    pd_dis = bus_idle_cfg[stab_chain_pkg::BIT_PD_DIS];
    chain_en = stab_ctrl[stab_chain_pkg::BIT_CHAIN_EN];
    accel_en = stab_ctrl[stab_chain_pkg::BIT_ACCEL_EN];
    st_field = stab_int[stab_chain_pkg::ST_LSB +: 2];
    next_pd = !pd_dis && (!irq1_routed || dyn_addr_assigned);
    next_irq2 = stab_int[stab_chain_pkg::BIT_DRDY2] ? stab_drdy
                                                    : irq2_other;
    next_three_wire = stab_ctrl[stab_chain_pkg::BIT_THREE_WIRE];
    next_gyro_act = chain_en;
    // Accel chain needs both enables set by the controller
    next_accel_act = chain_en && accel_en;
    // Forbidden code falls back to normal rather than an odd stimulus
    if (next_accel_act && st_field != stab_chain_pkg::ST_FORBIDDEN)
      next_selftest = st_field;
    else
      next_selftest = stab_chain_pkg::ST_NORMAL;
    next_range = fs_sel(stab_ctrl[stab_chain_pkg::BIT_LOW_RANGE],
      stab_ctrl[stab_chain_pkg::RANGE_LSB +: 2]);
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      irq1_pulldown_on <= 1'b0;
      irq_pin_second <= 1'b0;
      aux_three_wire <= 1'b0;
      gyro_stab_active <= 1'b0;
      accel_stab_active <= 1'b0;
      aux_gyro_visible <= 1'b0;
      aux_accel_visible <= 1'b0;
      first_lowpass_owned <= 1'b0;
      gyro_range <= stab_chain_pkg::GYRO_FS_250;
      accel_selftest <= stab_chain_pkg::ST_NORMAL;
    end else begin
      irq1_pulldown_on <= next_pd;
      irq_pin_second <= next_irq2;
      aux_three_wire <= next_three_wire;
      gyro_stab_active <= next_gyro_act;
      accel_stab_active <= next_accel_act;
      aux_gyro_visible <= next_gyro_act;
      aux_accel_visible <= next_accel_act;
      first_lowpass_owned <= next_gyro_act;
      gyro_range <= next_range;
      accel_selftest <= next_selftest;
    end
  end

  // Helpers run from the registered configuration
  assign lnk.avb_sel = bus_idle_cfg[stab_chain_pkg::AVB_LSB +: 2];
  assign lnk.ibi_request = ibi_request;
  assign lnk.bus_quiet = idle_sync;
  assign lnk.den_level = den_sync;
  assign lnk.den_pol = stab_int[stab_chain_pkg::BIT_POL];
  assign lnk.den_trig = stab_ctrl[stab_chain_pkg::BIT_LVL_TRIG];
  assign lnk.den_latch = stab_int[stab_chain_pkg::BIT_LATCH];
  // Only gyro samples are offered; accel data bypasses data-enable
  assign lnk.gyro_strobe = gyro_sample_strobe && chain_en;
  assign ibi_start = lnk.ibi_start;
  assign gyro_den_mark = lnk.gyro_mark;
  assign gyro_den_valid = lnk.gyro_valid;

  bus_avail_timer #(
    .W(stab_chain_pkg::AVB_CNT_W),
    .CYC_50US(CYC_50US),
    .CYC_1MS(CYC_1MS),
    .CYC_25MS(CYC_25MS)
  ) u_timer (
    .clk_sys(clk_sys),
    .rst(rst),
    .lnk(lnk.timer)
  );

  den_gate u_den (
    .clk_sys(clk_sys),
    .rst(rst),
    .lnk(lnk.den)
  );

  a_host_wr_block: assert property (@(posedge clk_sys) disable iff (rst)
    host_wr && host_addr == stab_chain_pkg::ADDR_STAB_CTRL
      && !(aux_wr && aux_addr == stab_chain_pkg::ADDR_STAB_CTRL)
      |=> $stable(stab_ctrl))
    else $error("primary write changed stabilization control");

  a_aux_wr_readback: assert property (@(posedge clk_sys) disable iff (rst)
    aux_wr && aux_addr == stab_chain_pkg::ADDR_STAB_INT
      && !host_rd ##1 host_rd && host_addr == stab_chain_pkg::ADDR_STAB_INT
      && !aux_wr
      |=> host_rdata == ($past(aux_wdata, 2) & stab_chain_pkg::MASK_STAB_INT))
    else $error("primary read missed aux write");

  a_pulldown_off: assert property (@(posedge clk_sys) disable iff (rst)
    bus_idle_cfg[stab_chain_pkg::BIT_PD_DIS] |=> !irq1_pulldown_on)
    else $error("pull-down on while disabled");

  a_irq2_override: assert property (@(posedge clk_sys) disable iff (rst)
    stab_int[stab_chain_pkg::BIT_DRDY2] |=>
      irq_pin_second == $past(stab_drdy))
    else $error("second irq pin not carrying stabilization ready");

  a_selftest_gate: assert property (@(posedge clk_sys) disable iff (rst)
    !(chain_en && accel_en) |=> accel_selftest == stab_chain_pkg::ST_NORMAL)
    else $error("accel self-test active with chain off");

  a_low_range: assert property (@(posedge clk_sys) disable iff (rst)
    stab_ctrl[stab_chain_pkg::BIT_LOW_RANGE] |=>
      gyro_range == stab_chain_pkg::GYRO_FS_125)
    else $error("low range bit ignored");

  a_accel_active: assert property (@(posedge clk_sys) disable iff (rst)
    accel_stab_active |-> gyro_stab_active && aux_accel_visible)
    else $error("accel chain active without gyro chain");

  a_rate_readout: assert property (@(posedge clk_sys) disable iff (rst)
    aux_rd && aux_addr == stab_chain_pkg::ADDR_RATE_DEV
      |=> aux_rdata == $past(rate_deviation, 2))
    else $error("rate deviation readout stale");

  a_three_wire: assert property (@(posedge clk_sys) disable iff (rst)
    ##1 aux_three_wire == $past(stab_ctrl[stab_chain_pkg::BIT_THREE_WIRE]))
    else $error("aux wire mode mismatch");

  a_idle_reserved: assert property (@(posedge clk_sys) disable iff (rst)
    (bus_idle_cfg & ~stab_chain_pkg::MASK_BUS_IDLE) == '0)
    else $error("reserved bus-idle bit stored");

  a_int_host_block: assert property (@(posedge clk_sys) disable iff (rst)
    host_wr && host_addr == stab_chain_pkg::ADDR_STAB_INT
      && !(aux_wr && aux_addr == stab_chain_pkg::ADDR_STAB_INT)
      |=> $stable(stab_int))
    else $error("primary write changed stabilization interrupt");

  a_rate_host: assert property (@(posedge clk_sys) disable iff (rst)
    host_rd && host_addr == stab_chain_pkg::ADDR_RATE_DEV
      |=> host_rdata == $past(rate_deviation, 2))
    else $error("primary rate deviation readout stale");

  a_host_idle_read: assert property (@(posedge clk_sys) disable iff (rst)
    !host_rd |=> host_rdata == stab_chain_pkg::READ_UNMAPPED)
    else $error("primary read data not cleared");

  a_aux_idle_read: assert property (@(posedge clk_sys) disable iff (rst)
    !aux_rd |=> aux_rdata == stab_chain_pkg::READ_UNMAPPED)
    else $error("aux read data not cleared");

  a_pulldown_on: assert property (@(posedge clk_sys) disable iff (rst)
    !bus_idle_cfg[stab_chain_pkg::BIT_PD_DIS]
      && (!irq1_routed || dyn_addr_assigned) |=> irq1_pulldown_on)
    else $error("pull-down missing while allowed");

  a_irq2_other: assert property (@(posedge clk_sys) disable iff (rst)
    !stab_int[stab_chain_pkg::BIT_DRDY2] |=>
      irq_pin_second == $past(irq2_other))
    else $error("second irq pin lost normal routing");

  a_gyro_chain: assert property (@(posedge clk_sys) disable iff (rst)
    chain_en |=> gyro_stab_active && aux_gyro_visible && first_lowpass_owned)
    else $error("gyro chain outputs missing");

  a_gyro_off: assert property (@(posedge clk_sys) disable iff (rst)
    !chain_en |=> !gyro_stab_active && !first_lowpass_owned)
    else $error("gyro chain active while disabled");

  a_selftest_legal: assert property (@(posedge clk_sys) disable iff (rst)
    accel_selftest != stab_chain_pkg::ST_FORBIDDEN)
    else $error("forbidden self-test code applied");

  a_range_field: assert property (@(posedge clk_sys) disable iff (rst)
    !stab_ctrl[stab_chain_pkg::BIT_LOW_RANGE] |=>
      gyro_range == {1'b0, $past(stab_ctrl[stab_chain_pkg::RANGE_LSB +: 2])})
    else $error("gyro range field ignored");

  a_accel_gate: assert property (@(posedge clk_sys) disable iff (rst)
    !chain_en |=> !accel_stab_active && !aux_accel_visible)
    else $error("accel chain active without chain enable");

  a_accel_visible: assert property (@(posedge clk_sys) disable iff (rst)
    chain_en && accel_en |=> accel_stab_active && aux_accel_visible)
    else $error("accel outputs not exposed");
endmodule // stab_chain_config_bank

//--- stab_chain_pkg.sv
// Constants and types shared by the stabilization config bank
package stab_chain_pkg;
  localparam int REG_W = 8;
  localparam logic [7:0] ADDR_BUS_IDLE = 8'h62;
  localparam logic [7:0] ADDR_RATE_DEV = 8'h63;
  localparam logic [7:0] ADDR_STAB_INT = 8'h6f;
  localparam logic [7:0] ADDR_STAB_CTRL = 8'h70;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;
  localparam logic [7:0] RESET_REG = 8'h00;
  // Writable bits; reserved bits are never stored and read zero
  localparam logic [7:0] MASK_BUS_IDLE = 8'h19;
  localparam logic [7:0] MASK_STAB_INT = 8'he3;
  localparam logic [7:0] MASK_STAB_CTRL = 8'h7f;
  localparam int BIT_PD_DIS = 0;
  localparam int AVB_LSB = 3;
  localparam int ST_LSB = 0;
  localparam int BIT_POL = 5;
  localparam int BIT_LATCH = 6;
  localparam int BIT_DRDY2 = 7;
  localparam int BIT_CHAIN_EN = 0;
  localparam int BIT_LOW_RANGE = 1;
  localparam int RANGE_LSB = 2;
  localparam int BIT_ACCEL_EN = 4;
  localparam int BIT_THREE_WIRE = 5;
  localparam int BIT_LVL_TRIG = 6;
  localparam int CLK_PERIOD_NS = 10;
  localparam int T_AVB_2US_NS = 2000;
  localparam int T_AVB_50US_NS = 50000;
  localparam int T_AVB_1MS_NS = 1000000;
  localparam int T_AVB_25MS_NS = 25000000;
  function automatic int cycles_min(input int t_ns);
    return (t_ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  endfunction
  localparam int CYC_AVB_2US = cycles_min(T_AVB_2US_NS);
  localparam int CYC_AVB_50US = cycles_min(T_AVB_50US_NS);
  localparam int CYC_AVB_1MS = cycles_min(T_AVB_1MS_NS);
  localparam int CYC_AVB_25MS = cycles_min(T_AVB_25MS_NS);
  localparam int AVB_CNT_W = 22;
  localparam logic [1:0] AVB_SEL_50US = 2'h0;
  localparam logic [1:0] AVB_SEL_2US = 2'h1;
  localparam logic [1:0] AVB_SEL_1MS = 2'h2;
  localparam logic [1:0] ST_NORMAL = 2'h0;
  localparam logic [1:0] ST_FORBIDDEN = 2'h3;
  localparam logic [1:0] DEN_MODE_TRIG = 2'h2;
  localparam logic [1:0] DEN_MODE_LATCH = 2'h3;
  localparam logic [1:0] RANGE_250 = 2'h0;
  localparam logic [1:0] RANGE_500 = 2'h1;
  localparam logic [1:0] RANGE_1000 = 2'h2;
  typedef enum logic [2:0] {
    GYRO_FS_250 = 3'h0, GYRO_FS_500 = 3'h1, GYRO_FS_1000 = 3'h2,
    GYRO_FS_2000 = 3'h3, GYRO_FS_125 = 3'h4
  } gyro_fs_t;
  typedef enum logic [2:0] {
    AVB_IDLE = 3'h1, AVB_WAIT = 3'h2, AVB_GRANT = 3'h4
  } avb_state_t;
endpackage

//--- stab_link_if.sv
// Carrier between the bank and its timer and data-enable helpers
`timescale 1ns/1ps
interface stab_link_if;
  logic [1:0] avb_sel;
  logic ibi_request;
  logic bus_quiet;
  logic ibi_start;
  logic den_level;
  logic den_pol;
  logic den_trig;
  logic den_latch;
  logic gyro_strobe;
  logic gyro_mark;
  logic gyro_valid;
  modport timer (input avb_sel, input ibi_request, input bus_quiet,
    output ibi_start);
  modport den (input den_level, input den_pol, input den_trig,
    input den_latch, input gyro_strobe, output gyro_mark,
    output gyro_valid);
endinterface

//--- bus_avail_timer.sv
// Idle-time wait before an in-band interrupt may start
`timescale 1ns/1ps
module bus_avail_timer #(
  parameter int W = stab_chain_pkg::AVB_CNT_W,
  parameter int CYC_50US = stab_chain_pkg::CYC_AVB_50US,
  parameter int CYC_1MS = stab_chain_pkg::CYC_AVB_1MS,
  parameter int CYC_25MS = stab_chain_pkg::CYC_AVB_25MS
) (
  input wire logic clk_sys,
  input wire logic rst,
  stab_link_if.timer lnk
);
  stab_chain_pkg::avb_state_t state, next_state;
  logic [W-1:0] count, next_count;
  logic [W-1:0] last;
  function automatic logic [W-1:0] last_cycle(input logic [1:0] s);
    if (s == stab_chain_pkg::AVB_SEL_50US) return W'(CYC_50US - 1);
    else if (s == stab_chain_pkg::AVB_SEL_2US)
      return W'(stab_chain_pkg::CYC_AVB_2US - 1);
    else if (s == stab_chain_pkg::AVB_SEL_1MS) return W'(CYC_1MS - 1);
    else return W'(CYC_25MS - 1);
  endfunction
  always_comb begin
    last = last_cycle(lnk.avb_sel);
    next_state = state;
    next_count = count;
    case (state)
      stab_chain_pkg::AVB_IDLE: begin
        next_count = '0;
        if (lnk.ibi_request) next_state = stab_chain_pkg::AVB_WAIT;
      end
      stab_chain_pkg::AVB_WAIT: begin
        // Any bus activity restarts the quiet interval
        if (!lnk.bus_quiet) next_count = '0;
        else if (count >= last) next_state = stab_chain_pkg::AVB_GRANT;
        else next_count = count + W'(1);
      end
      default: begin
        next_state = stab_chain_pkg::AVB_IDLE;
        next_count = '0;
      end
    endcase
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state <= stab_chain_pkg::AVB_IDLE;
      count <= '0;
      lnk.ibi_start <= 1'b0;
    end else begin
      state <= next_state;
      count <= next_count;
      lnk.ibi_start <= (next_state == stab_chain_pkg::AVB_GRANT);
    end
  end
  a_ibi_quiet_wait: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(lnk.ibi_start) |-> $past(count) >= $past(last)
      && $past(lnk.bus_quiet))
    else $error("in-band interrupt started before idle time");
endmodule // bus_avail_timer

//--- den_gate.sv
// Data-enable marking of gyroscope stabilization samples
`timescale 1ns/1ps
module den_gate (
  input wire logic clk_sys,
  input wire logic rst,
  stab_link_if.den lnk
);
  logic held, next_held;
  logic active;
  logic [1:0] mode;
  logic next_mark;
  always_comb begin
    active = lnk.den_pol ? lnk.den_level : !lnk.den_level;
    mode = {lnk.den_trig, lnk.den_latch};
    // A new active level wins over the clear by a sample
    next_held = active || (held && !lnk.gyro_strobe);
    next_mark = 1'b0;
    if (mode == stab_chain_pkg::DEN_MODE_TRIG) next_mark = active;
    else if (mode == stab_chain_pkg::DEN_MODE_LATCH)
      next_mark = active || held;
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      held <= 1'b0;
      lnk.gyro_mark <= 1'b0;
      lnk.gyro_valid <= 1'b0;
    end else begin
      held <= next_held;
      lnk.gyro_mark <= lnk.gyro_strobe && next_mark;
      lnk.gyro_valid <= lnk.gyro_strobe;
    end
  end
  a_den_no_mode: assert property (@(posedge clk_sys) disable iff (rst)
    !lnk.den_trig |=> !lnk.gyro_mark)
    else $error("gyro sample marked with data-enable mode off");
endmodule // den_gate

//--- ctrl_partner.sv
// Controller model driving the primary and auxiliary register ports
`timescale 1ns/1ps
module ctrl_partner (
  input wire logic clk_sys,
  output logic [7:0] host_addr,
  output logic [7:0] host_wdata,
  output logic host_wr,
  output logic host_rd,
  output logic [7:0] aux_addr,
  output logic [7:0] aux_wdata,
  output logic aux_wr,
  output logic aux_rd
);
  initial begin
    {host_addr, host_wdata, aux_addr, aux_wdata} = 32'h0;
    {host_wr, host_rd, aux_wr, aux_rd} = 4'h0;
  end
  // One access per call; strobe stands across exactly one rising edge
  task automatic access(input logic aux, input logic wr,
    input logic [7:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (wr && !aux && a == 8'h62) v = v & 8'h19;
    if (wr && aux && a == 8'h6f && v[1:0] == 2'h3) v[1:0] = 2'h0;
    if (wr && aux && a == 8'h70 && v[4]) v[0] = 1'b1;
    @(negedge clk_sys);
    if (aux) begin
      {aux_addr, aux_wdata, aux_wr, aux_rd} <= {a, v, wr, !wr};
    end else begin
      {host_addr, host_wdata, host_wr, host_rd} <= {a, v, wr, !wr};
    end
    @(negedge clk_sys);
    // Inverted leftovers so a stale address never looks valid
    if (aux) begin
      {aux_addr, aux_wdata, aux_wr, aux_rd} <= {~a, ~v, 2'b00};
    end else begin
      {host_addr, host_wdata, host_wr, host_rd} <= {~a, ~v, 2'b00};
    end
  endtask
endmodule // ctrl_partner

//--- tb_stab_chain_config_bank.sv
// Self-checking bench for the stabilization configuration bank
`timescale 1ns/1ps
module tb_stab_chain_config_bank;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [7:0] host_addr, host_wdata, aux_addr, aux_wdata;
  logic host_wr, host_rd, aux_wr, aux_rd;
  logic [7:0] host_rdata, aux_rdata;
  logic [7:0] rate_deviation = 8'h00;
  logic irq1_routed = 1'b0;
  logic dyn_addr_assigned = 1'b0;
  logic ibi_request = 1'b0;
  logic bus_idle_pin = 1'b1;
  logic data_enable_input = 1'b0;
  logic gyro_sample_strobe = 1'b0;
  logic stab_drdy = 1'b0;
  logic irq2_other = 1'b0;
  logic irq1_pulldown_on, irq_pin_second, ibi_start, aux_three_wire;
  logic gyro_stab_active, accel_stab_active, aux_gyro_visible;
  logic aux_accel_visible, first_lowpass_owned, gyro_den_mark;
  logic gyro_den_valid;
  stab_chain_pkg::gyro_fs_t gyro_range;
  logic [1:0] accel_selftest;
  logic [7:0] qh[$];
  logic [7:0] qa[$];
  logic qd[$];
  logic hseen = 1'b0;
  logic aseen = 1'b0;
  logic [7:0] regs [5] = '{8'h62, 8'h63, 8'h6f, 8'h70, 8'h64};
  logic [7:0] d;
  logic ce;
  int fails = 0;
  int check_count = 0;
  int seed = 16609;
  int lat;

  always #5 clk_sys = ~clk_sys;

  // Short counts keep the long idle waits inside the run budget
  stab_chain_config_bank #(.CYC_50US(20), .CYC_1MS(40), .CYC_25MS(60))
    stab_chain_config_bank_i (.*);
  ctrl_partner ctrl_partner_i (.*);

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic final_report();
    $display("Checks %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic rd(input logic aux, input logic [7:0] a,
    input logic [7:0] e);
    if (aux) qa.push_back(e);
    else qh.push_back(e);
    ctrl_partner_i.access(aux, 1'b0, a, 8'h00);
  endtask

  task automatic wr(input logic aux, input logic [7:0] a,
    input logic [7:0] v);
    ctrl_partner_i.access(aux, 1'b1, a, v);
  endtask

  // Register lands one edge after the write, outputs one edge later
  task automatic settle();
    repeat (3) @(negedge clk_sys);
  endtask

  task automatic strobe(input logic push, input logic e);
    if (push) qd.push_back(e);
    @(negedge clk_sys);
    gyro_sample_strobe <= 1'b1;
    @(negedge clk_sys);
    gyro_sample_strobe <= 1'b0;
    repeat (3) @(negedge clk_sys);
  endtask

  task automatic timer(input logic [1:0] sel, input int n, input int g);
    wr(1'b0, 8'h62, {3'h0, sel, 3'h0});
    settle();
    lat = 0;
    ibi_request <= 1'b1;
    while (ibi_start !== 1'b1 && lat < 400) begin
      @(negedge clk_sys);
      lat++;
      bus_idle_pin <= (lat != g);
    end
    ibi_request <= 1'b0;
    chk(lat >= n + g && lat <= n + g + 8, 1'b1);
  endtask

  // Result watcher: each answer takes the oldest note off its queue
  always @(posedge clk_sys) begin
    hseen <= host_rd;
    aseen <= aux_rd;
  end
  always @(negedge clk_sys) begin
    if (hseen === 1'b1) begin
      if (qh.size() == 0) chk(1'b1, 1'b0);
      else chk(host_rdata, qh.pop_front());
    end
    if (aseen === 1'b1) begin
      if (qa.size() == 0) chk(1'b1, 1'b0);
      else chk(aux_rdata, qa.pop_front());
    end
    if (gyro_den_valid === 1'b1) begin
      if (qd.size() == 0) chk(1'b1, 1'b0);
      else chk(gyro_den_mark, qd.pop_front());
    end
  end

  initial begin
    repeat (30000) @(posedge clk_sys);
    fails++;
    $display("Error at %0t: watchdog expired", $time);
    final_report();
  end

  initial begin
    repeat (20) @(negedge clk_sys);
    rst <= 1'b0;
    foreach (regs[i]) begin
      rd(1'b0, regs[i], 8'h00);
      rd(1'b1, regs[i], 8'h00);
    end
    strobe(1'b0, 1'b0);
    wr(1'b0, 8'h70, 8'($random(seed)));
    wr(1'b0, 8'h6f, 8'($random(seed)));
    wr(1'b0, 8'h63, 8'($random(seed)));
    wr(1'b1, 8'h62, 8'h19);
    rd(1'b0, 8'h70, 8'h00);
    rd(1'b1, 8'h6f, 8'h00);
    rd(1'b0, 8'h62, 8'h00);
    wr(1'b1, 8'h70, 8'hff);
    wr(1'b1, 8'h6f, 8'hff);
    wr(1'b0, 8'h70, 8'($random(seed)));
    rd(1'b0, 8'h70, 8'h7f);
    rd(1'b1, 8'h6f, 8'he0);
    wr(1'b0, 8'h62, 8'hff);
    rd(1'b1, 8'h62, 8'h19);
    repeat (3) begin
      rate_deviation <= 8'($random(seed));
      repeat (3) @(negedge clk_sys);
      rd(1'b0, 8'h63, rate_deviation);
      rd(1'b1, 8'h63, rate_deviation);
    end
    for (int k = 0; k < 8; k++) begin
      wr(1'b0, 8'h62, {7'h0, k[0]});
      irq1_routed <= k[1];
      dyn_addr_assigned <= k[2];
      settle();
      chk(irq1_pulldown_on, !k[0] && (!k[1] || k[2]));
      wr(1'b1, 8'h6f, {k[0], 7'h0});
      stab_drdy <= k[1];
      irq2_other <= k[2];
      settle();
      chk(irq_pin_second, k[0] ? k[1] : k[2]);
    end
    for (int k = 0; k < 32; k++) begin
      d = {2'h0, k[0] ^ k[1], k[4], k[3:2], k[1], k[0]};
      ce = k[0] | k[4];
      wr(1'b1, 8'h70, d);
      settle();
      chk(gyro_range, k[1] ? 3'h4 : {1'b0, k[3:2]});
      chk({gyro_stab_active, aux_gyro_visible, first_lowpass_owned},
        {3{ce}});
      chk({accel_stab_active, aux_accel_visible}, {2{ce & k[4]}});
      chk(aux_three_wire, k[0] ^ k[1]);
      rd(1'b0, 8'h70, d | {7'h0, k[4]});
    end
    for (int k = 0; k < 8; k++) begin
      wr(1'b1, 8'h70, k[2] ? 8'h11 : 8'h01);
      wr(1'b1, 8'h6f, {6'h0, k[1:0]});
      settle();
      chk(accel_selftest, (k[2] && k[1:0] != 3) ? k[1:0] : 2'h0);
    end
    for (int m = 0; m < 3; m++) begin
      for (int p = 0; p < 2; p++) begin
        data_enable_input <= !p[0];
        wr(1'b1, 8'h70, {1'b0, m != 0, 6'h01});
        wr(1'b1, 8'h6f, {1'b0, m == 2, p[0], 5'h0});
        data_enable_input <= p[0];
        repeat (4) @(negedge clk_sys);
        strobe(1'b1, m != 0);
        data_enable_input <= !p[0];
        repeat (4) @(negedge clk_sys);
        strobe(1'b1, m == 2);
        strobe(1'b1, 1'b0);
      end
    end
    timer(2'h0, 20, 0);
    timer(2'h1, 200, 0);
    timer(2'h2, 40, 0);
    timer(2'h3, 60, 0);
    timer(2'h0, 20, 10);
    @(negedge clk_sys);
    rst <= 1'b1;
    repeat (2) @(negedge clk_sys);
    rst <= 1'b0;
    rd(1'b0, 8'h70, 8'h00);
    rd(1'b1, 8'h6f, 8'h00);
    rd(1'b0, 8'h62, 8'h00);
    repeat (4) @(negedge clk_sys);
    chk(qh.size() + qa.size() + qd.size(), 8'h00);
    final_report();
  end
endmodule // tb_stab_chain_config_bank
